// *** btx_cfg.svh ***
`ifndef BTX_CFG_SVH
`define BTX_CFG_SVH
// Notes on behaviour
// - Bonded control pair selects data, fill, special, sync
// - Dual: B bit0 high starts sync on A,B
// - Dual: D bit0 high starts sync on C,D
// - Mode bit1 high bonds all four channels
// - Quad: A/B bit0 steer all, own bit1
// - Quad: C and D bit0 ignored
// - Self-test emits repeating 511-character LFSR pattern
// - Latch open: low enable bit enables self-test
// - Latch closed: self-test enables held
// - Test reset low sets self-test latch high
// - Self-test ignores parallel data and control inputs
// - Non-mid receive clock: sync before each pass
// - Loopback forces enabled drivers to steady one
// - Output latch open: bus bit enables driver
// - Both outputs off powers channel down
// - Output latch closed: enables held
// - Odd bits: second out, tx test; even: first
// - Multiplier picks ten or twenty per rate select
`define BTX_K285      8'hbc
`define BTX_SYNC_ALT  8'hb5
`define BTX_SYNC_LAST 4'hf
`define BTX_LFSR_SEED 9'h1ff
`define BTX_LATCH_RST 8'hff
`define BTX_OE_RST    8'h00
`define BTX_MULT_LO   5'h0a
`define BTX_MULT_HI   5'h14
`define BTX_RXCK_MID  2'h1
`define BTX_BUF_FULL  2'h2
`endif

// *** btx_encode.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "btx_cfg.svh"
module btx_encode
  import btx_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            srst,
  input  wire logic            test_reset_n,
  input  wire logic [1:0]      bonding_mode_sel,
  input  wire logic [3:0][7:0] tx_parallel_byte,
  input  wire logic [1:0]      tx_char_ctrl_a,
  input  wire logic [1:0]      tx_char_ctrl_b,
  input  wire logic [1:0]      tx_char_ctrl_c,
  input  wire logic [1:0]      tx_char_ctrl_d,
  input  wire logic            in_valid,
  output logic                 in_ready,
  output logic                 char_valid,
  input  wire logic            char_ready,
  output logic [3:0][7:0]      char_byte,
  output logic [3:0]           char_is_k,
  input  wire logic [7:0]      shared_enable_bus,
  input  wire logic            selftest_latch_en,
  input  wire logic            out_enable_latch_en,
  input  wire logic [1:0]      rx_clock_sel,
  input  wire logic            local_loopback_en,
  input  wire logic            ref_rate_sel,
  output logic [7:0]           serial_out_en,
  output logic [7:0]           serial_drive_one,
  output logic [3:0]           chan_power_down,
  output logic [3:0]           tx_selftest_on,
  output logic [3:0]           rx_selftest_on,
  output logic [4:0]           pll_mult
);

  btx_state_type s_r;
  btx_state_type s_nxt;
  logic          push;
  logic          pop;
  logic          need_sync;
  logic [3:0]    bist_on;
  logic [3:0]    b0;
  logic [3:0]    b1;
  logic [3:0]    trig;

  ////////////////////////////////////////////////////////////////////////////
  // Control decode

  assign push      = (s_r.cnt != `BTX_BUF_FULL);
  assign pop       = (s_r.cnt != 2'h0) && char_ready;
  assign need_sync = (rx_clock_sel != `BTX_RXCK_MID);
  assign b1        = {tx_char_ctrl_d[1], tx_char_ctrl_c[1], tx_char_ctrl_b[1], tx_char_ctrl_a[1]};

  always_comb begin
    b0   = {tx_char_ctrl_d[0], tx_char_ctrl_c[0], tx_char_ctrl_b[0], tx_char_ctrl_a[0]};
    trig = 4'h0;
    if (bonding_mode_sel[1]) begin
      // C and D bit 0 never looked at here
      b0   = {4{tx_char_ctrl_a[0]}};
      trig = {4{tx_char_ctrl_b[0]}};
    end else if (bonding_mode_sel[0]) begin
      b0   = {{2{tx_char_ctrl_c[0]}}, {2{tx_char_ctrl_a[0]}}};
      trig = {{2{tx_char_ctrl_d[0]}}, {2{tx_char_ctrl_b[0]}}};
    end
  end

  for (genvar g = 0; g < 4; g++) begin : g_map
    assign bist_on[g]         = ~s_r.bist[2*g+1];
    assign tx_selftest_on[g]  = ~s_r.bist[2*g+1];
    assign rx_selftest_on[g]  = ~s_r.bist[2*g];
    assign chan_power_down[g] = ~s_r.oe[2*g] & ~s_r.oe[2*g+1];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    btx_chan_type c;
    btx_code_type code;
    logic [7:0]   obyte;
    logic         ok;
    logic         wpos;
    c     = s_r.chan[0];
    code  = btx_cd_fill;
    obyte = `BTX_K285;
    ok    = 1'b1;
    wpos  = (s_r.cnt == 2'h1) && !pop;
    s_nxt = s_r;
    // Two-entry buffer so a stalled receiver loses no character
    if (pop) begin
      s_nxt.bbyte[0] = s_r.bbyte[1];
      s_nxt.bk[0]    = s_r.bk[1];
    end
    s_nxt.cnt = s_r.cnt + {1'b0, push} - {1'b0, pop};
    for (int i = 0; i < 4; i++) begin
      c     = s_r.chan[i];
      code  = btx_cd_fill;
      obyte = `BTX_K285;
      ok    = 1'b1;
      if (push) begin
        if (bist_on[i]) begin
          // Inputs ignored from here on
          if (!c.state[1]) begin
            c.lfsr  = `BTX_LFSR_SEED;
            c.cnt   = 4'h0;
            c.state = need_sync ? btx_st_bsync : btx_st_bist;
          end
        end else if (c.state[1]) begin
          c.state = btx_st_norm;
          c.cnt   = 4'h0;
        end
        if (c.state == btx_st_norm) begin
          code = btx_code_type'({b1[i], b0[i]});
          if (!in_valid) begin
            code = btx_cd_fill;
          end else if (trig[i]) begin
            code = btx_cd_sync;
          end
          case (code)
            btx_cd_data: begin
              obyte = tx_parallel_byte[i];
              ok    = 1'b0;
            end
            btx_cd_fill: obyte = `BTX_K285;
            btx_cd_spec: obyte = tx_parallel_byte[i];
            default:     c.state = btx_st_sync;
          endcase
        end
        case (c.state)
          btx_st_sync, btx_st_bsync: begin
            // Runs all sixteen characters unless the self-test enable changes; inputs unread
            obyte = c.cnt[0] ? `BTX_SYNC_ALT : `BTX_K285;
            ok    = ~c.cnt[0];
            if (c.cnt == `BTX_SYNC_LAST) begin
              c.state = (c.state == btx_st_bsync) ? btx_st_bist : btx_st_norm;
            end
            c.cnt = c.cnt + 4'h1;
          end
          btx_st_bist: begin
            // x^9+x^5+1, period 511; bit 8 doubles as the K flag
            obyte  = c.lfsr[7:0];
            ok     = c.lfsr[8];
            c.lfsr = {c.lfsr[7:0], c.lfsr[8] ^ c.lfsr[4]};
            if (c.lfsr == `BTX_LFSR_SEED && need_sync) begin
              c.state = btx_st_bsync;
            end
          end
          default: ;
        endcase
        s_nxt.bbyte[wpos][i] = obyte;
        s_nxt.bk[wpos][i]    = ok;
      end
      s_nxt.chan[i] = c;
    end
    // Registers track the bus while open, so they behave as latches
    if (out_enable_latch_en) begin
      s_nxt.oe = shared_enable_bus;
    end
    if (selftest_latch_en) begin
      s_nxt.bist = shared_enable_bus;
    end
    if (!test_reset_n) begin
      s_nxt.bist = `BTX_LATCH_RST;
    end
    s_nxt.lpbk = local_loopback_en;
    s_nxt.mult = ref_rate_sel ? `BTX_MULT_HI : `BTX_MULT_LO;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_r      <= '0;
      s_r.bist <= `BTX_LATCH_RST;
      s_r.oe   <= `BTX_OE_RST;
      s_r.mult <= `BTX_MULT_LO;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign in_ready         = push;
  assign char_valid       = (s_r.cnt != 2'h0);
  assign char_byte        = s_r.bbyte[0];
  assign char_is_k        = s_r.bk[0];
  assign serial_out_en    = s_r.oe;
  assign serial_drive_one = s_r.lpbk ? s_r.oe : 8'h00;
  assign pll_mult         = s_r.mult;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_oe_pass: assert property (
    out_enable_latch_en |=> serial_out_en == $past(shared_enable_bus))
    else $error("output enable not passed through");

  a_oe_hold: assert property (
    !out_enable_latch_en |=> $stable(serial_out_en))
    else $error("output enable changed while latched");

  a_bist_hold: assert property (
    !selftest_latch_en && test_reset_n |=> $stable(tx_selftest_on) && $stable(rx_selftest_on))
    else $error("self-test enable changed while latched");

  a_bist_reset: assert property (
    !test_reset_n |=> tx_selftest_on == 4'h0 && rx_selftest_on == 4'h0)
    else $error("test reset left self-test on");

  a_bist_map: assert property (
    selftest_latch_en && test_reset_n |=>
      tx_selftest_on == ~$past({shared_enable_bus[7], shared_enable_bus[5],
                                shared_enable_bus[3], shared_enable_bus[1]}))
    else $error("self-test bit mapping wrong");

  a_pwr_down: assert property (
    out_enable_latch_en && shared_enable_bus[1:0] == 2'h0 |=> chan_power_down[0])
    else $error("channel A not powered down");

  a_loop_one: assert property (
    local_loopback_en && out_enable_latch_en |=> serial_drive_one == $past(shared_enable_bus))
    else $error("loopback did not force enabled drivers");

  a_mult_sel: assert property (
    ref_rate_sel |=> pll_mult == `BTX_MULT_HI)
    else $error("multiplier not twenty");

  a_sync_steps: assert property (
    s_r.chan[0].state == btx_st_sync && push && s_r.chan[0].cnt != `BTX_SYNC_LAST
      && !bist_on[0] |=> s_r.chan[0].state == btx_st_sync
      && s_r.chan[0].cnt == $past(s_r.chan[0].cnt) + 4'h1)
    else $error("word sync broken early");

  a_dual_trig: assert property (
    bonding_mode_sel == 2'h1 && tx_char_ctrl_b[0] && in_valid && push
      && s_r.chan[0].state == btx_st_norm && s_r.chan[1].state == btx_st_norm
      && !bist_on[0] && !bist_on[1]
      |=> s_r.chan[0].state == btx_st_sync && s_r.chan[1].state == btx_st_sync)
    else $error("dual bond B trigger missed");

  a_dual_trig_cd: assert property (
    bonding_mode_sel == 2'h1 && tx_char_ctrl_d[0] && in_valid && push
      && s_r.chan[2].state == btx_st_norm && s_r.chan[3].state == btx_st_norm
      && !bist_on[2] && !bist_on[3]
      |=> s_r.chan[2].state == btx_st_sync && s_r.chan[3].state == btx_st_sync)
    else $error("dual bond D trigger missed");

  a_char_hold: assert property (
    char_valid && !char_ready |=> char_valid && $stable(char_byte) && $stable(char_is_k))
    else $error("head character changed while stalled");

  a_buf_full: assert property (
    s_r.cnt == `BTX_BUF_FULL |-> !in_ready)
    else $error("slot offered with buffer full");

  a_slot_out: assert property (
    in_ready |=> char_valid)
    else $error("slot did not reach the buffer head");

  a_rx_map: assert property (
    selftest_latch_en && test_reset_n |=>
      rx_selftest_on == ~$past({shared_enable_bus[6], shared_enable_bus[4],
                                shared_enable_bus[2], shared_enable_bus[0]}))
    else $error("receive self-test bit mapping wrong");

  a_loop_off: assert property (
    !local_loopback_en |=> serial_drive_one == 8'h00)
    else $error("drivers forced without loopback");

  a_mult_lo: assert property (
    !ref_rate_sel |=> pll_mult == `BTX_MULT_LO)
    else $error("multiplier not ten");

  a_pwr_up: assert property (
    out_enable_latch_en && shared_enable_bus[0] |=> !chan_power_down[0])
    else $error("channel A powered down with an output on");

  a_quad_trig: assert property (
    bonding_mode_sel[1] && tx_char_ctrl_b[0] && in_valid && push
      && s_r.chan[0].state == btx_st_norm && s_r.chan[1].state == btx_st_norm
      && s_r.chan[2].state == btx_st_norm && s_r.chan[3].state == btx_st_norm
      && bist_on == 4'h0
      |=> s_r.chan[2].state == btx_st_sync && s_r.chan[3].state == btx_st_sync)
    else $error("quad bond trigger missed");

  a_quad_ignore: assert property (
    bonding_mode_sel[1] && in_valid && s_r.cnt == 2'h0 && !bist_on[2]
      && s_r.chan[2].state == btx_st_norm && !tx_char_ctrl_a[0] && !tx_char_ctrl_b[0]
      && !tx_char_ctrl_c[1]
      |=> !char_is_k[2] && char_byte[2] == $past(tx_parallel_byte[2]))
    else $error("channel C bit0 interpreted in quad");

  a_bist_keep: assert property (
    s_r.chan[0].state == btx_st_bist && bist_on[0] && push |=> s_r.chan[0].state[1])
    else $error("self-test left while enabled");

  a_bist_stop: assert property (
    !bist_on[0] && s_r.chan[0].state[1] && push |=> !s_r.chan[0].state[1])
    else $error("self-test kept after disable");

  c_buf_full:  cover property (s_r.cnt == `BTX_BUF_FULL);
  c_bist_run:  cover property (s_r.chan[0].state == btx_st_bist);
  c_sync_quad: cover property (bonding_mode_sel[1] && s_r.chan[3].state == btx_st_sync);
  c_loopback:  cover property (serial_drive_one != 8'h00);

endmodule // btx_encode
`default_nettype wire

// *** btx_pkg.sv ***
package btx_pkg;
  typedef enum logic [1:0] {
    btx_st_norm  = 2'b00,
    btx_st_sync  = 2'b01,
    btx_st_bsync = 2'b10,
    btx_st_bist  = 2'b11
  } btx_st_type;
  typedef enum logic [1:0] {
    btx_cd_data = 2'b00,
    btx_cd_fill = 2'b01,
    btx_cd_spec = 2'b10,
    btx_cd_sync = 2'b11
  } btx_code_type;
  typedef struct packed {
    btx_st_type state;
    logic [3:0] cnt;
    logic [8:0] lfsr;
  } btx_chan_type;
  typedef struct packed {
    btx_chan_type [3:0]     chan;
    logic [1:0][3:0][7:0]   bbyte;
    logic [1:0][3:0]        bk;
    logic [1:0]             cnt;
    logic [7:0]             bist;
    logic [7:0]             oe;
    logic                   lpbk;
    logic [4:0]             mult;
  } btx_state_type;
endpackage

// *** btx_rx_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module btx_rx_model (
  input  wire logic            clk,
  input  wire logic            srst,
  input  wire logic            stall,
  input  wire logic            char_valid,
  output logic                 char_ready,
  input  wire logic [3:0][7:0] char_byte,
  input  wire logic [3:0]      char_is_k,
  output logic [3:0][7:0]      last_byte,
  output logic [3:0]           last_k
);
  // Every accepted word, K flags on top, for sequence checks
  logic [35:0] qa [$];
  // Stall lets the bench act as a slow receiver
  assign char_ready = !stall;
  always @(posedge clk) begin
    if (!srst && char_valid && char_ready) begin
      last_byte <= char_byte;
      last_k    <= char_is_k;
      qa.push_back({char_is_k, char_byte});
    end
  end
endmodule // btx_rx_model
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic            clk = 0, srst = 1, test_reset_n = 1, in_valid = 1, stall = 0;
  logic [1:0]      bonding_mode_sel = 0, tx_char_ctrl_a = 0, tx_char_ctrl_b = 0;
  logic [1:0]      tx_char_ctrl_c = 0, tx_char_ctrl_d = 0, rx_clock_sel = 2'h1;
  logic [3:0][7:0] tx_parallel_byte = 32'h44332211, char_byte, last_byte;
  logic [7:0]      shared_enable_bus = 0, serial_out_en, serial_drive_one;
  logic            selftest_latch_en = 0, out_enable_latch_en = 0, local_loopback_en = 0;
  logic            ref_rate_sel = 0, in_ready, char_valid, char_ready;
  logic [3:0]      char_is_k, last_k, chan_power_down, tx_selftest_on, rx_selftest_on;
  logic [4:0]      pll_mult;
  logic [35:0]     head;
  int              error_cnt = 0, comparisons = 0;
  btx_encode   i_btx_encode (.*);
  btx_rx_model i_btx_rx_model (.*);
  always #4 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("Comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic look(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic sync_chk(input int ch, input bit syn);
    int f;
    f = -1;
    foreach (i_btx_rx_model.qa[i])
      if (f < 0 && i_btx_rx_model.qa[i][32+ch]) f = i;
    chk(f >= 0, syn);
    for (int j = 0; syn && f >= 0 && j < 17; j++)
      chk({i_btx_rx_model.qa[f+j][32+ch], i_btx_rx_model.qa[f+j][8*ch+:8]},
          j == 16 ? 9'h011 * (ch + 1) : (j % 2 ? 9'h0b5 : 9'h1bc));
  endtask
  // Changing inputs would break the period if they leaked into the pattern
  task automatic period_chk(input int p);
    i_btx_rx_model.qa.delete();
    for (int i = 0; i < 1200; i++) begin
      tick(1);
      tx_parallel_byte <= {4{i[7:0]}};
      tx_char_ctrl_a   <= i[9:8];
    end
    for (int k = 0; k < 600; k++)
      chk(i_btx_rx_model.qa[k][32] * 256 + i_btx_rx_model.qa[k][7:0],
          i_btx_rx_model.qa[k+p][32] * 256 + i_btx_rx_model.qa[k+p][7:0]);
    tick(1);
    tx_parallel_byte <= 32'h44332211;
    tx_char_ctrl_a   <= 0;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge clk);
    srst <= 0;
    @(negedge clk);
    chk({char_valid, in_ready, tx_selftest_on, serial_out_en}, 14'h1000);
    chk(pll_mult, 5'h0a);
    bonding_mode_sel <= 2'b01;
    for (int k = 0; k < 3; k++) begin
      tick(1);
      tx_char_ctrl_a <= k[1:0];
      look(4);
      chk({last_k[0], last_byte[0]}, k == 1 ? 9'h1bc : {k[1], 8'h11});
      chk({last_k[1], last_byte[1]}, k == 1 ? 9'h1bc : 9'h022);
    end
    tick(1);
    tx_char_ctrl_a <= 0;
    for (int s = 0; s < 2; s++) begin
      look(4);
      i_btx_rx_model.qa.delete();
      tick(1);
      tx_char_ctrl_b <= s ? 2'b00 : 2'b01;
      tx_char_ctrl_d <= s ? 2'b01 : 2'b00;
      tick(1);
      tx_char_ctrl_b <= 0;
      tx_char_ctrl_d <= 0;
      look(30);
      sync_chk(2 * s, 1);
      sync_chk(2 * s + 1, 1);
      sync_chk(2 - 2 * s, 0);
    end
    tick(1);
    bonding_mode_sel <= 2'b10;
    tx_char_ctrl_c   <= 2'b11;
    tx_char_ctrl_d   <= 2'b01;
    look(4);
    chk({last_k, last_byte}, 36'h444332211);
    tick(1);
    tx_char_ctrl_a <= 2'b01;
    tx_char_ctrl_c <= 0;
    tx_char_ctrl_d <= 0;
    look(4);
    chk({last_k, last_byte}, 36'hfbcbcbcbc);
    tick(1);
    tx_char_ctrl_a    <= 0;
    bonding_mode_sel  <= 0;
    shared_enable_bus <= 8'hfd;
    selftest_latch_en <= 1;
    look(3);
    chk({tx_selftest_on, rx_selftest_on}, 8'h10);
    tick(1);
    selftest_latch_en <= 0;
    tick(1);
    shared_enable_bus <= 8'h00;
    look(3);
    chk(tx_selftest_on, 4'h1);
    period_chk(511);
    test_reset_n <= 0;
    tick(1);
    test_reset_n <= 1;
    look(1);
    chk(tx_selftest_on, 4'h0);
    look(4);
    chk({last_k[0], last_byte[0]}, 9'h011);
    tick(1);
    rx_clock_sel      <= 2'h0;
    shared_enable_bus <= 8'hfd;
    selftest_latch_en <= 1;
    look(3);
    period_chk(527);
    selftest_latch_en <= 0;
    test_reset_n      <= 0;
    out_enable_latch_en <= 1;
    shared_enable_bus <= 8'h0c;
    tick(1);
    test_reset_n <= 1;
    look(2);
    chk({serial_out_en, chan_power_down}, 12'h0cd);
    chk(serial_drive_one, 8'h00);
    tick(1);
    out_enable_latch_en <= 0;
    local_loopback_en   <= 1;
    ref_rate_sel        <= 1;
    tick(1);
    shared_enable_bus <= 8'hf3;
    look(3);
    chk(serial_out_en, 8'h0c);
    chk(serial_drive_one, 8'h0c);
    chk(pll_mult, 5'h14);
    tick(1);
    ref_rate_sel <= 0;
    stall        <= 1;
    look(2);
    chk(pll_mult, 5'h0a);
    for (int i = 0; i < 6 && in_ready; i++) look(1);
    chk({in_ready, char_valid}, 2'b01);
    head = {char_is_k, char_byte};
    look(3);
    chk({char_is_k, char_byte}, head);
    tick(1);
    stall <= 0;
    look(1);
    chk({last_k, last_byte}, head);
    conclude();
  end
endmodule // tb_top
`default_nettype wire
